// ===== logic/ldfc_chan.sv
// one led channel: drive, ramp window and open/short fault timing
`timescale 1ns/1ps
module ldfc_chan
  import ldfc_pkg::*;
#(
  parameter int FAULT_CYC_P = FAULT_CYC,
  parameter int HICCUP_CYC_P = HICCUP_CYC
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // control
  input wire logic i_active,
  input wire logic i_pwm_on,
  input wire logic i_latch_mode,
  input wire logic [RAMP_W-1:0] i_ramp_len,
  // synchronised comparators
  input wire logic i_short,
  input wire logic i_open,
  // results
  output logic o_drive,
  output logic o_ramp,
  output logic o_short_flag,
  output logic o_open_flag
);
  localparam int CNT_W = $clog2(FAULT_CYC_P + 1);

  // counter is shared by all phases, so the longest time must be fault time
  if (FAULT_CYC_P < HICCUP_CYC_P || HICCUP_CYC_P <= PROBE_CYC) begin : g_chk
    $error("ldfc_chan: fault time must exceed hiccup time, hiccup the probe");
  end

  ldfc_ch_state_t state_q, state_d; // protection state
  logic [CNT_W-1:0] cnt_q, cnt_d; // persistence, hiccup or probe time
  logic drive_q, drive_d; // current sink on
  logic sflag_q, sflag_d; // short flag
  logic oflag_q, oflag_d; // open flag
  logic [RAMP_W-1:0] ramp_q; // ramp cycles left
  logic ramp_on_q; // ramp window

  // decode of condition and counter ends
  wire logic cond = i_short | i_open;
  wire logic cnt_fault = cnt_q == CNT_W'(FAULT_CYC_P - 1);
  wire logic cnt_hic = cnt_q == CNT_W'(HICCUP_CYC_P - 1);
  wire logic cnt_probe = cnt_q == CNT_W'(PROBE_CYC - 1);
  wire logic [CNT_W-1:0] cnt_inc = CNT_W'(cnt_q + 1'b1);
  wire logic rise = drive_d & ~drive_q;
  wire logic [RAMP_W-1:0] ramp_d = rise ? i_ramp_len :
                                   (drive_d && ramp_q != '0) ? RAMP_W'(ramp_q - 1'b1) : '0;

  // protection sequencing
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    drive_d = 1'b0;
    sflag_d = sflag_q;
    oflag_d = oflag_q;
    if (!i_active) begin
      // disabled channel or device: forget faults
      state_d = CH_RUN;
      cnt_d = '0;
      sflag_d = 1'b0;
      oflag_d = 1'b0;
    end else begin
      unique case (state_q)
        CH_RUN: begin
          drive_d = i_pwm_on; // R19
          // condition only counts while conducting; pwm off time holds it
          if (drive_q && cond) begin
            cnt_d = cnt_inc; // R11 R17
            if (cnt_fault) begin
              sflag_d = i_short; // R3 R11
              oflag_d = i_open; // R3 R14 R17
              state_d = i_latch_mode ? CH_LATCH : CH_OFF; // R18
              cnt_d = '0;
              drive_d = 1'b0;
            end
          end else if (drive_q) begin
            cnt_d = '0;
          end
        end
        CH_OFF: begin
          cnt_d = cnt_inc; // R12
          if (cnt_hic) begin
            state_d = CH_PROBE;
            cnt_d = '0;
          end
        end
        CH_PROBE: begin
          drive_d = 1'b1; // R12
          cnt_d = cnt_inc;
          if (cnt_probe) begin
            drive_d = 1'b0;
            cnt_d = '0;
            if (cond) begin
              state_d = CH_OFF;
              sflag_d = i_short;
              oflag_d = i_open;
            end else begin
              state_d = CH_RUN; // R18
              sflag_d = 1'b0;
              oflag_d = 1'b0;
            end
          end
        end
        CH_LATCH: begin
          drive_d = 1'b0; // R18
        end
      endcase
    end
  end

  // state registers
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      state_q <= CH_RUN;
      cnt_q <= '0;
      drive_q <= 1'b0;
      sflag_q <= 1'b0;
      oflag_q <= 1'b0;
      ramp_q <= '0;
      ramp_on_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      drive_q <= drive_d;
      sflag_q <= sflag_d;
      oflag_q <= oflag_d;
      ramp_q <= ramp_d; // R10
      ramp_on_q <= ramp_d != '0;
    end
  end

  assign o_drive = drive_q;
  assign o_ramp = ramp_on_q;
  assign o_short_flag = sflag_q;
  assign o_open_flag = oflag_q;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  property p_r11;
    $rose(sflag_q | oflag_q) && $past(state_q) == CH_RUN |-> $past(cnt_q) == CNT_W'(FAULT_CYC_P - 1) && !drive_q;
  endproperty
  a_r11: assert property (p_r11) else $error("fault flag set before persistence time"); // R11

  property p_r12;
    state_q == CH_PROBE && $past(state_q) == CH_PROBE && i_active |-> drive_q;
  endproperty
  a_r12: assert property (p_r12) else $error("channel not conducting in probe window"); // R12

  property p_r18;
    state_q == CH_LATCH && i_active |=> state_q == CH_LATCH && !drive_q;
  endproperty
  a_r18: assert property (p_r18) else $error("latched channel left off state"); // R18

  property p_r10;
    $rose(drive_q) && $past(i_ramp_len) != '0 |-> ramp_on_q;
  endproperty
  a_r10: assert property (p_r10) else $error("ramp window missing at rising edge"); // R10
endmodule : ldfc_chan

// ===== logic/ldfc_core.sv
// top of the led dimming and fault core: timebase, refresh pin, channels
`timescale 1ns/1ps
module ldfc_core
  import ldfc_pkg::*;
#(
  parameter int NCH_P = NCH,
  parameter int FAULT_CYC_P = FAULT_CYC,
  parameter int HICCUP_CYC_P = HICCUP_CYC,
  parameter logic [ADDR_W-ADDR_LOW_W-1:0] ADDR_HIGH = 3'h2 // arbitrary value
) (
  // clocks and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_link_clk,
  // pins from outside
  input wire logic i_enable_pin,
  input wire logic [ADDR_LOW_W-1:0] i_addr_sel,
  input wire logic [NCH_P-1:0] i_short_cmp,
  input wire logic [NCH_P-1:0] i_open_cmp,
  // settings written over the serial interface
  input wire logic [NCH_P-1:0] i_chan_enable,
  input wire logic [NCH_P*DUTY_W-1:0] i_pwm_duty,
  input wire logic [NCH_P*AMP_W-1:0] i_channel_amplitude_code,
  input wire logic [1:0] i_pwm_freq_select,
  input wire logic i_phase_shift_enable,
  input wire logic [1:0] i_slew_select,
  input wire logic [DIV_W-1:0] i_refresh_divider,
  input wire logic i_fault_indicate_enable,
  input wire logic i_latch_mode,
  input wire logic [1:0] i_short_threshold_select,
  // channel outputs
  output logic [NCH_P-1:0] o_chan_drive,
  output logic [NCH_P-1:0] o_chan_ramp,
  output logic [NCH_P*AMP_W-1:0] o_channel_amplitude_code,
  output logic [1:0] o_short_threshold_select,
  // status
  output logic [NCH_P-1:0] o_short_flag,
  output logic [NCH_P-1:0] o_open_flag,
  output logic o_fault_any,
  output logic o_device_on,
  output logic [ADDR_W-1:0] o_i2c_addr,
  // shared refresh / fault pin, link clock domain
  output logic o_refresh_fault_pin_o,
  output logic o_refresh_fault_pin_oe
);
  // phase offsets of all channels must fit inside one period
  if (NCH_P < 1 || NCH_P > NCH) begin : g_chk
    $error("ldfc_core: channel count out of range");
  end

  //==========================================================
  // pin synchronisers
  //==========================================================
  logic en_m, en_s; // enable pin
  logic [ADDR_LOW_W-1:0] addr_m, addr_s; // address decode
  logic [NCH_P-1:0] sc_m, sc_s; // short comparators
  logic [NCH_P-1:0] oc_m, oc_s; // open comparators

  // two flops per pin; first stage feeds only the second
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      en_m <= 1'b0;
      en_s <= 1'b0;
      addr_m <= '0;
      addr_s <= '0;
      sc_m <= '0;
      sc_s <= '0;
      oc_m <= '0;
      oc_s <= '0;
    end else begin
      en_m <= i_enable_pin;
      en_s <= en_m; // R5
      addr_m <= i_addr_sel;
      addr_s <= addr_m;
      sc_m <= i_short_cmp;
      sc_s <= sc_m;
      oc_m <= i_open_cmp;
      oc_s <= oc_m; // R14
    end
  end

  //==========================================================
  // pwm timebase
  //==========================================================
  logic [7:0] pre_q; // cycles within a duty step
  logic [DUTY_W-1:0] per_q; // shared period counter

  // step length follows the frequency code
  wire logic [7:0] step_len = step_cyc(i_pwm_freq_select); // R15 R8
  // >= keeps a code change mid-step from overrunning
  wire logic step_end = pre_q >= 8'(step_len - 8'h01);
  wire logic per_end = per_q >= DUTY_W'(PER_STEPS - 1);
  wire logic [7:0] ph = i_phase_shift_enable ? ph_steps(i_pwm_freq_select) : 8'h00; // R9 R16
  wire logic [RAMP_W-1:0] ramp_len = ramp_cyc(i_slew_select); // R9 R10

  // prescaler and period counter, parked while disabled
  always_ff @(posedge i_mclk) begin
    if (i_reset || !en_s) begin
      pre_q <= '0;
      per_q <= '0;
    end else if (step_end) begin
      pre_q <= '0;
      per_q <= per_end ? '0 : DUTY_W'(per_q + 1'b1); // R19
    end else begin
      pre_q <= 8'(pre_q + 1'b1);
    end
  end

  //==========================================================
  // channels
  //==========================================================
  logic [NCH_P*AMP_W-1:0] amp_q; // amplitude codes to the current dacs

  for (genvar c = 0; c < NCH_P; c++) begin : g_ch
    // channel c lags channel 0 by c phase steps
    wire logic [DUTY_W-1:0] off = DUTY_W'(c * int'(ph)); // R16
    wire logic [DUTY_W-1:0] pos = (per_q >= off) ? DUTY_W'(per_q - off)
                                                : DUTY_W'(per_q + PER_STEPS - off);
    // duty zero never exceeds pos, so the channel stays off
    wire logic pwm_on = pos < i_pwm_duty[c*DUTY_W +: DUTY_W]; // R2 R19
    wire logic active = en_s & i_chan_enable[c]; // R1 R5

    ldfc_chan #(
      .FAULT_CYC_P(FAULT_CYC_P),
      .HICCUP_CYC_P(HICCUP_CYC_P)
    ) u_chan (
      .i_mclk(i_mclk),
      .i_reset(i_reset),
      .i_active(active),
      .i_pwm_on(pwm_on),
      .i_latch_mode(i_latch_mode),
      .i_ramp_len(ramp_len),
      .i_short(sc_s[c]),
      .i_open(oc_s[c]),
      .o_drive(o_chan_drive[c]),
      .o_ramp(o_chan_ramp[c]),
      .o_short_flag(o_short_flag[c]),
      .o_open_flag(o_open_flag[c])
    );

    // amplitude acts apart from pwm; zero while the channel or device is disabled
    always_ff @(posedge i_mclk) begin
      if (i_reset) begin
        amp_q[c*AMP_W +: AMP_W] <= '0;
      end else begin
        amp_q[c*AMP_W +: AMP_W] <= active ? i_channel_amplitude_code[c*AMP_W +: AMP_W] : '0; // R2
      end
    end
  end

  assign o_channel_amplitude_code = amp_q;

  //==========================================================
  // status and straps
  //==========================================================
  logic fault_any_q; // any flag set
  logic dev_on_q; // device enabled
  logic [ADDR_W-1:0] addr_q; // target address
  logic [1:0] sth_q; // short threshold code

  // decode maps ten resistor choices; anything above clamps to the last
  wire logic [ADDR_LOW_W-1:0] addr_low = (addr_s < ADDR_LOW_W'(ADDR_CHOICES)) ? addr_s
                                        : ADDR_LOW_W'(ADDR_CHOICES - 1);
  wire logic any_flag = |(o_short_flag | o_open_flag);

  // address is sampled only while off, so it never moves in operation
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      fault_any_q <= 1'b0;
      dev_on_q <= 1'b0;
      addr_q <= {ADDR_HIGH, {ADDR_LOW_W{1'b0}}};
      sth_q <= '0;
    end else begin
      fault_any_q <= any_flag; // R3
      dev_on_q <= en_s;
      sth_q <= i_short_threshold_select; // R13
      if (!en_s) begin
        addr_q <= {ADDR_HIGH, addr_low}; // R6
      end
    end
  end

  assign o_fault_any = fault_any_q;
  assign o_device_on = dev_on_q;
  assign o_i2c_addr = addr_q;
  assign o_short_threshold_select = sth_q;

  //==========================================================
  // refresh generator
  //==========================================================
  logic [RFSH_PRE_W-1:0] rt_q; // steps per refresh tick
  logic [DIV_W-1:0] rc_q; // ticks per half period
  logic rf_lvl_q; // refresh square wave

  wire logic div_zero = i_refresh_divider == '0;
  wire logic rt_end = step_end && rt_q == RFSH_PRE_W'(RFSH_PRE - 1);
  wire logic rc_end = rc_q >= DIV_W'(i_refresh_divider - 1'b1);

  // toggles every divider ticks; divider zero holds the level high
  always_ff @(posedge i_mclk) begin
    if (i_reset || !en_s || div_zero) begin
      rt_q <= '0;
      rc_q <= '0;
      rf_lvl_q <= 1'b1;
    end else if (step_end) begin
      rt_q <= RFSH_PRE_W'(rt_q + 1'b1);
      if (rt_end) begin
        rc_q <= rc_end ? '0 : DIV_W'(rc_q + 1'b1);
        rf_lvl_q <= rc_end ? ~rf_lvl_q : rf_lvl_q; // R7
      end
    end
  end

  //==========================================================
  // pin request, mclk side
  //==========================================================
  logic pin_drv_q; // pin driven
  logic pin_lvl_q; // level when driven

  // fault indication wins over the refresh wave; off device lets go
  wire logic flt_low = i_fault_indicate_enable && fault_any_q; // R3 R4
  wire logic pin_drv_d = flt_low || (en_s && !div_zero); // R4
  wire logic pin_lvl_d = !flt_low && rf_lvl_q; // R4

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      pin_drv_q <= 1'b0;
      pin_lvl_q <= 1'b1;
    end else begin
      pin_drv_q <= pin_drv_d;
      pin_lvl_q <= pin_lvl_d;
    end
  end

  //==========================================================
  // link clock domain: pin flops
  //==========================================================
  logic lr_m, lr_q; // reset into link domain
  logic ld_m, ld_q; // drive level
  logic ll_m, ll_q; // pin level
  // two level syncs: a skew of one link cycle may show a brief high,
  // which the pull-up shows anyway

  // reset synchroniser
  always_ff @(posedge i_link_clk) begin
    lr_m <= i_reset;
    lr_q <= lr_m;
  end

  // pin level synchronisers; second stage drives the pin
  always_ff @(posedge i_link_clk) begin
    ld_m <= pin_drv_q;
    ll_m <= pin_lvl_q;
    if (lr_q) begin
      ld_q <= 1'b0;
      ll_q <= 1'b1;
    end else begin
      ld_q <= ld_m;
      ll_q <= ll_m;
    end
  end

  assign o_refresh_fault_pin_oe = ld_q;
  assign o_refresh_fault_pin_o = ll_q;

  //==========================================================
  // checks, mclk domain
  //==========================================================
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  property p_r1;
    1'b1 |=> (o_chan_drive & ~$past(i_chan_enable)) == '0;
  endproperty
  a_r1: assert property (p_r1) else $error("disabled channel is driven"); // R1

  property p_r5;
    !en_s |=> o_chan_drive == '0 && o_device_on == 1'b0;
  endproperty
  a_r5: assert property (p_r5) else $error("channels on while device disabled"); // R5

  property p_r19;
    i_pwm_duty[DUTY_W-1:0] == '0 && !o_short_flag[0] && !o_open_flag[0] |=> !o_chan_drive[0];
  endproperty
  a_r19: assert property (p_r19) else $error("zero duty channel conducts"); // R19

  property p_r4;
    i_fault_indicate_enable && o_fault_any |=> pin_drv_q && !pin_lvl_q;
  endproperty
  a_r4: assert property (p_r4) else $error("fault not shown low on pin"); // R4

  property p_r3;
    any_flag |=> o_fault_any;
  endproperty
  a_r3: assert property (p_r3) else $error("fault flag not summarised"); // R3

  property p_r6;
    o_i2c_addr[ADDR_LOW_W-1:0] < ADDR_LOW_W'(ADDR_CHOICES) && o_i2c_addr[ADDR_W-1:ADDR_LOW_W] == ADDR_HIGH;
  endproperty
  a_r6: assert property (p_r6) else $error("address outside ten choices"); // R6

  property p_r7;
    $changed(rf_lvl_q) && !div_zero && en_s |=> $stable(rf_lvl_q)[*8];
  endproperty
  a_r7: assert property (p_r7) else $error("refresh half period too short"); // R7

  property p_r15;
    i_pwm_freq_select == 2'h1 |-> step_len == 8'h61 && ph_steps(2'h1) == 8'h29;
  endproperty
  a_r15: assert property (p_r15) else $error("250 Hz step length wrong"); // R15 R8

  property p_r8;
    en_s && $past(en_s) && !$past(step_end) |-> $stable(per_q);
  endproperty
  a_r8: assert property (p_r8) else $error("period counter moved inside a step"); // R8
endmodule : ldfc_core

// ===== logic/ldfc_pkg.sv
// shared constants and types of the led dimming and fault core
//==========================================================
// Behaviour
// R1: sixteen channels, each switched on separately.
// R2: own 12-bit duty, own 6-bit amplitude.
// R3: protection pulls indication low, sets flag.
// R4: shared pin: refresh, or fault low.
// R5: enable pin low disables the device.
// R6: address low nibble from ten-way decode.
// R7: divider 0x1A9 at code 01 near 300 Hz.
// R8: one duty step near 0.97 us at 250 Hz.
// R9: ramp rate and phase shift are configurable.
// R10: ramp code 01 is 5 us, 11 is 20 us.
// R11: short declared after 4 ms above threshold.
// R12: hiccup retries every 1 ms for 32 us.
// R13: two-bit short threshold select code.
// R14: open flagged from low-voltage comparator.
// R15: frequency codes give 220/250/280/330 Hz.
// R16: phase shift delays each channel 40 us.
// R17: open declared after 4 ms.
// R18: latch keeps channel off; hiccup retries, releases.
// R19: duty against shared counter; zero is off.
//==========================================================
package ldfc_pkg;
  // sizes
  localparam int NCH = 16;
  localparam int DUTY_W = 12;
  localparam int AMP_W = 6;
  localparam int DIV_W = 10;
  localparam int ADDR_W = 7;
  localparam int ADDR_LOW_W = 4;
  localparam int ADDR_CHOICES = 10;
  localparam int RAMP_W = 12;
  // clock and unit scaling
  localparam int CLK_NS = 10;
  localparam int NS_PER_US = 1000;
  localparam int US_PER_MS = 1000;
  localparam longint NS_PER_S = 1000000000;
  // pwm period: duty/4095, counter wraps after the last step
  localparam int PER_STEPS = 4095;
  localparam int HZ_220 = 220;
  localparam int HZ_250 = 250;
  localparam int HZ_280 = 280;
  localparam int HZ_330 = 330;
  // phase shift between neighbouring channels
  localparam int PHASE_US = 40;
  localparam int PHASE_CYC = PHASE_US * NS_PER_US / CLK_NS;
  // ramp times
  localparam int RAMP_US_1 = 5;
  localparam int RAMP_US_2 = 10;
  localparam int RAMP_US_3 = 20;
  // fault timing
  localparam int FAULT_MS = 4;
  localparam int HICCUP_MS = 1;
  localparam int PROBE_US = 32;
  localparam int FAULT_CYC = FAULT_MS * US_PER_MS * NS_PER_US / CLK_NS;
  localparam int HICCUP_CYC = HICCUP_MS * US_PER_MS * NS_PER_US / CLK_NS;
  localparam int PROBE_CYC = PROBE_US * NS_PER_US / CLK_NS;
  // refresh tick every four pwm steps, so it scales with the pwm rate
  localparam int RFSH_PRE = 4;
  localparam int RFSH_PRE_W = 2;

  // channel protection states
  typedef enum logic [1:0] {CH_RUN, CH_OFF, CH_PROBE, CH_LATCH} ldfc_ch_state_t;

  // clock cycles per duty step for a frequency code (period / 4096)
  function automatic logic [7:0] step_cyc(input logic [1:0] sel);
    longint hz;
    unique case (sel)
      2'h0: hz = HZ_220;
      2'h1: hz = HZ_250;
      2'h2: hz = HZ_280;
      2'h3: hz = HZ_330;
    endcase
    return 8'(NS_PER_S / (hz * (2 ** DUTY_W)) / CLK_NS);
  endfunction : step_cyc

  // duty steps between neighbouring channels when phase shift is on
  function automatic logic [7:0] ph_steps(input logic [1:0] sel);
    return 8'(PHASE_CYC / int'(step_cyc(sel)));
  endfunction : ph_steps

  // clock cycles of the rising ramp for a ramp code
  function automatic logic [RAMP_W-1:0] ramp_cyc(input logic [1:0] sel);
    int us;
    unique case (sel)
      2'h0: us = 0;
      2'h1: us = RAMP_US_1;
      2'h2: us = RAMP_US_2;
      2'h3: us = RAMP_US_3;
    endcase
    return RAMP_W'(us * NS_PER_US / CLK_NS);
  endfunction : ramp_cyc
endpackage : ldfc_pkg

// ===== tb/ldfc_host.sv
// host model: drives the core's settings and its enable pin
`timescale 1ns/1ps
module ldfc_host
  import ldfc_pkg::*;
(
  // clock
  input wire logic i_mclk,
  // enable pin
  output logic o_enable_pin,
  // settings
  output logic [NCH-1:0] o_chan_enable,
  output logic [NCH*DUTY_W-1:0] o_pwm_duty,
  output logic [NCH*AMP_W-1:0] o_channel_amplitude_code,
  output logic [1:0] o_pwm_freq_select,
  output logic o_phase_shift_enable,
  output logic [1:0] o_slew_select,
  output logic [DIV_W-1:0] o_refresh_divider,
  output logic o_fault_indicate_enable,
  output logic o_latch_mode,
  output logic [1:0] o_short_threshold_select
);
  //==========================================================
  // writes
  // power-on: device off, settings cleared, 250 Hz default
  initial begin
    {o_enable_pin, o_chan_enable, o_pwm_duty, o_channel_amplitude_code} = '0;
    {o_phase_shift_enable, o_slew_select, o_refresh_divider} = '0;
    {o_fault_indicate_enable, o_latch_mode, o_short_threshold_select} = '0;
    o_pwm_freq_select = 2'h1;
  end
  // enable pin level, changed on an edge
  task automatic set_enable(input logic v);
    @(posedge i_mclk);
    o_enable_pin <= v;
  endtask : set_enable
  // one channel: switch, duty and amplitude
  task automatic set_ch(input int c, input logic en, input logic [DUTY_W-1:0] d, input logic [AMP_W-1:0] a);
    @(posedge i_mclk);
    o_chan_enable[c] <= en;
    o_pwm_duty[c*DUTY_W +: DUTY_W] <= d;
    o_channel_amplitude_code[c*AMP_W +: AMP_W] <= a;
  endtask : set_ch
  // global settings; callers change the frequency only while disabled
  task automatic set_glob(input logic [1:0] f, input logic ps, input logic [1:0] sl, input logic [DIV_W-1:0] dv,
                          input logic fi, input logic lt, input logic [1:0] th);
    @(posedge i_mclk);
    o_pwm_freq_select <= f;
    o_phase_shift_enable <= ps;
    o_slew_select <= sl;
    o_refresh_divider <= dv;
    o_fault_indicate_enable <= fi;
    o_latch_mode <= lt;
    o_short_threshold_select <= th;
  endtask : set_glob
endmodule : ldfc_host

// ===== tb/tb.sv
// self-checking bench for the led dimming and fault core
`timescale 1ns/1ps
module tb;
  import ldfc_pkg::*;
  //==========================================================
  // signals
  localparam int FLT = 8000; // short fault counts keep the run brief
  localparam int HIC = 4000;
  localparam logic [2:0] AHI = 3'h5; // arbitrary value
  logic i_mclk = 1'b0;
  logic i_link_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [3:0] i_addr_sel = 4'hC; // above nine, clamps
  logic [15:0] i_short_cmp = 16'h0000;
  logic [15:0] i_open_cmp = 16'h0000;
  wire en_pin, phase_shift_enable, fi_en, lt_mode;
  wire [15:0] ch_en;
  wire [191:0] duty;
  wire [95:0] amp;
  wire [1:0] fsel, slew, short_threshold_select;
  wire [9:0] rdiv;
  logic [15:0] drive, ramp, sflag, oflag;
  logic [95:0] amp_o;
  logic [1:0] sth_o;
  logic fany, dev_on, pin_o, pin_oe;
  logic [6:0] addr;
  int mismatches = 0;
  int checked = 0;
  int stp[4] = '{110, 97, 87, 73}; // cycles per duty step
  int rmp[4] = '{0, 500, 1000, 2000}; // ramp cycles per code
  initial begin
    forever #5 i_mclk = ~i_mclk;
  end
  // offset link clock, edges never meet the main ones
  initial begin
    #7;
    forever #15 i_link_clk = ~i_link_clk;
  end
  ldfc_host host (.i_mclk(i_mclk), .o_enable_pin(en_pin), .o_chan_enable(ch_en), .o_pwm_duty(duty),
    .o_channel_amplitude_code(amp), .o_pwm_freq_select(fsel), .o_phase_shift_enable(phase_shift_enable),
    .o_slew_select(slew), .o_refresh_divider(rdiv), .o_fault_indicate_enable(fi_en),
    .o_latch_mode(lt_mode), .o_short_threshold_select(short_threshold_select));
  ldfc_core #(.FAULT_CYC_P(FLT), .HICCUP_CYC_P(HIC), .ADDR_HIGH(AHI)) dut (.i_mclk(i_mclk), .i_reset(i_reset),
    .i_link_clk(i_link_clk), .i_enable_pin(en_pin), .i_addr_sel(i_addr_sel), .i_short_cmp(i_short_cmp),
    .i_open_cmp(i_open_cmp), .i_chan_enable(ch_en), .i_pwm_duty(duty), .i_channel_amplitude_code(amp),
    .i_pwm_freq_select(fsel), .i_phase_shift_enable(phase_shift_enable), .i_slew_select(slew), .i_refresh_divider(rdiv),
    .i_fault_indicate_enable(fi_en), .i_latch_mode(lt_mode), .i_short_threshold_select(short_threshold_select),
    .o_chan_drive(drive), .o_chan_ramp(ramp), .o_channel_amplitude_code(amp_o), .o_short_threshold_select(sth_o),
    .o_short_flag(sflag), .o_open_flag(oflag), .o_fault_any(fany), .o_device_on(dev_on), .o_i2c_addr(addr),
    .o_refresh_fault_pin_o(pin_o), .o_refresh_fault_pin_oe(pin_oe));
  //==========================================================
  // helpers
  // compare within a tolerance; an unknown never matches
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp, input int tol = 0);
    logic ok;
    ok = (seen + tol >= exp) && (seen <= exp + tol);
    checked++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("wrong value %s expected %0d seen %0d", what, exp, seen);
    end
  endtask : chk
  task automatic final_report();
    if (mismatches == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : tick
  function automatic logic sig(input int w);
    case (w)
      0: return drive[0];
      1: return sflag[0];
      2: return oflag[0];
      default: return pin_o;
    endcase
  endfunction : sig
  // cycles until a watched output reaches a level; bound ends the run
  task automatic wait_lvl(input int w, input logic v, input int lim, output int n);
    n = 0;
    while (sig(w) !== v) begin
      tick(1);
      n++;
      if (n > lim) begin
        mismatches++;
        $display("wrong value wait %0d expected %0d seen timeout", w, v);
        final_report();
      end
    end
  endtask : wait_lvl
  // restart the device with new global settings
  task automatic restart(input logic [1:0] f, input logic [1:0] sl, input logic lt);
    int n;
    host.set_enable(1'b0);
    tick(2);
    host.set_glob(f, 1'b1, sl, 10'h000, 1'b1, lt, 2'h1);
    tick(4);
    host.set_enable(1'b1);
    wait_lvl(0, 1'b1, 20, n);
  endtask : restart
  //==========================================================
  // scenarios
  task automatic sc_idle();
    host.set_glob(2'h1, 1'b0, 2'h0, 10'h000, 1'b1, 1'b1, 2'h1);
    tick(6);
    chk("address", addr, {AHI, 4'h9});
    chk("drive", drive, 16'h0000);
    chk("device on", dev_on, 1'b0);
    chk("pin enable", pin_oe, 1'b0);
    chk("threshold", sth_o, 2'h1);
  endtask : sc_idle
  // every frequency and ramp code, phase shift on
  task automatic sc_pwm();
    int hi, rp, d1, bad, st;
    host.set_ch(0, 1'b1, 12'h032, 6'h2A);
    host.set_ch(1, 1'b1, 12'h001, 6'h15);
    host.set_ch(2, 1'b0, 12'hFFF, 6'h3F);
    host.set_ch(3, 1'b1, 12'h000, 6'h01);
    for (int f = 0; f < 4; f++) begin
      st = stp[f];
      restart(2'(f), 2'(f), 1'b1);
      hi = 0;
      rp = 0;
      d1 = 0;
      bad = 0;
      for (int k = 0; k < 60 * st; k++) begin
        tick(1);
        hi += drive[0];
        rp += ramp[0];
        if (d1 == 0 && drive[1] === 1'b1) begin
          d1 = k + 1;
        end
        if (drive[3:2] !== 2'b00) begin
          bad++;
        end
      end
      chk("duty time", hi, 50 * st, 3);
      chk("ramp time", rp, rmp[f], 3);
      chk("phase delay", d1, (4000 / st) * st, 3);
      chk("idle channels", bad, 0);
    end
    chk("amplitude", amp_o[23:0], {6'h01, 6'h00, 6'h15, 6'h2A});
  endtask : sc_pwm
  task automatic sc_latch();
    int n;
    host.set_ch(0, 1'b1, 12'hFFF, 6'h3F);
    restart(2'h1, 2'h0, 1'b1);
    @(posedge i_mclk);
    i_short_cmp <= 16'h0001;
    wait_lvl(1, 1'b1, FLT + 20, n);
    chk("short time", n, FLT + 3, 4);
    chk("flags", {drive[0], oflag[0]}, 2'b00);
    tick(12);
    chk("pin", {fany, pin_oe, pin_o}, 3'b110);
    @(posedge i_mclk);
    i_short_cmp <= 16'h0000;
    tick(HIC + 4000);
    chk("latched", {sflag[0], drive[0]}, 2'b10);
  endtask : sc_latch
  task automatic sc_hiccup();
    int n;
    restart(2'h1, 2'h0, 1'b0);
    @(posedge i_mclk);
    i_open_cmp <= 16'h0001;
    wait_lvl(2, 1'b1, FLT + 20, n);
    chk("open time", n, FLT + 3, 4);
    wait_lvl(0, 1'b1, HIC + 20, n);
    chk("retry gap", n, HIC, 3);
    wait_lvl(0, 1'b0, 3300, n);
    chk("probe time", n, PROBE_CYC, 3);
    @(posedge i_mclk);
    i_open_cmp <= 16'h0000;
    wait_lvl(2, 1'b0, HIC + 3300, n);
    tick(12);
    chk("released", {drive[0], pin_oe, fany}, 3'b100);
  endtask : sc_hiccup
  task automatic sc_refresh();
    int n;
    host.set_glob(2'h1, 1'b0, 2'h0, 10'h003, 1'b0, 1'b0, 2'h2);
    wait_lvl(3, 1'b0, 3000, n);
    wait_lvl(3, 1'b1, 3000, n);
    wait_lvl(3, 1'b0, 3000, n);
    chk("refresh half", n, 3 * 4 * 97, 4);
    chk("pin enable", pin_oe, 1'b1);
    chk("device on", dev_on, 1'b1);
    chk("threshold", sth_o, 2'h2);
  endtask : sc_refresh
  // short reset; link flops settle from the reset mclk side
  initial begin
    repeat (2) @(posedge i_mclk);
    i_reset <= 1'b0;
    sc_idle();
    sc_pwm();
    sc_latch();
    sc_hiccup();
    sc_refresh();
    final_report();
  end
endmodule : tb
